/* hdl/pic_pkg.sv */
// Constants, types and encodings for the cascaded interrupt controller pair.
// Assumes a single clock domain; the host drives I/O strobes as one-cycle pulses.
// Contract
// - Write at base with bit 4 set is the first init word, restarting init.
// - After init, base writes with bit 4 clear go to the operational words.
// - Level-trigger bit of first init word is ignored and reads as one.
// - Call-interval bit of first init word is ignored.
// - Command codes 001 nonspecific EOI, 011 specific EOI, 010 no operation.
// - Code 100 sets auto-EOI rotation, 000 clears it, 101 rotates on EOI.
// - Code 110 sets lowest priority, 111 specific EOI with rotate, both use level.
// - Command bits 4:3 are 00; bit 4 set means first init word.
// - Level field picks line 0-7 on master, 8-15 on slave.
// - Special mask mode set or cleared only when its enable bit is one.
// - Poll bit makes the next base-address read of that controller an acknowledge.
// - Low bits 10 select request register, 11 in-service, others no change.
// - Vector base from second init word; acknowledge replaces low bits by level.
// - First init word resets to 19h.
// - Base plus one writes outside init set line masks; master line 2 masks slave.
// - Slave interrupt output feeds master request line 2.
package pic_pkg;
   localparam logic [7:0] PIC_MST_BASE = 8'h20;
   localparam logic [7:0] PIC_SLV_BASE = 8'ha0;
   localparam logic [7:0] PIC_INIT_WORD_ONE_RST = 8'h19;
   localparam logic [7:0] PIC_LEVEL_TRIGGER_BIT_ONE = 8'h08;
   localparam logic [7:0] PIC_IMR_RST = 8'h00;
   localparam logic [2:0] PIC_LOWEST_RST = 3'h7;
   localparam logic [2:0] PIC_CASC_LINE = 3'h2;
   localparam logic [2:0] PIC_SPUR_LINE = 3'h7;
   localparam logic [4:0] PIC_VBASE_RST = 5'h00;
   localparam int PIC_SEL_BIT = 4;
   localparam int PIC_MISC_BIT = 3;
   localparam int PIC_POLL_BIT = 2;
   localparam int PIC_SMM_BIT = 6;
   localparam int PIC_SPECIAL_MASK_ENABLE_BIT = 5;
   localparam int PIC_RDEN_BIT = 1;
   localparam int PIC_RDSEL_BIT = 0;
   localparam int PIC_IC4_BIT = 0;
   localparam int PIC_AEOI_BIT = 1;
   localparam logic [2:0] PIC_OP_ROT_CLR = 3'b000;
   localparam logic [2:0] PIC_OP_NS_EOI = 3'b001;
   localparam logic [2:0] PIC_OP_NOP = 3'b010;
   localparam logic [2:0] PIC_OP_SP_EOI = 3'b011;
   localparam logic [2:0] PIC_OP_ROT_SET = 3'b100;
   localparam logic [2:0] PIC_OP_ROT_NS = 3'b101;
   localparam logic [2:0] PIC_OP_SET_PRI = 3'b110;
   localparam logic [2:0] PIC_OP_ROT_SP = 3'b111;

   typedef enum logic [1:0] {
      PIC_STEP_OPER = 2'b00,
      PIC_STEP_VEC = 2'b01,
      PIC_STEP_CAS = 2'b10,
      PIC_STEP_FOUR = 2'b11
   } pic_step_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] data;
   } pic_io_t;

   typedef struct packed {
      logic [7:0] init_word_one;
      logic [4:0] vbase;
      logic [7:0] line_mask_register;
      logic [7:0] request_register;
      logic [7:0] in_service_register;
      logic [2:0] lowest;
      logic aeoi;
      logic rot_aeoi;
      logic special_mask_bit;
      logic poll;
      logic read_isr;
      pic_step_t step;
   } pic_ctl_t;

   localparam pic_ctl_t PIC_CTL_RST = '{init_word_one: PIC_INIT_WORD_ONE_RST, vbase: PIC_VBASE_RST,
      line_mask_register: PIC_IMR_RST, request_register: 8'h00, in_service_register: 8'h00, lowest: PIC_LOWEST_RST, aeoi: 1'b0,
      rot_aeoi: 1'b0, special_mask_bit: 1'b0, poll: 1'b0, read_isr: 1'b0, step: PIC_STEP_OPER};
endpackage

/* hdl/pic_pair.sv */
// Master and slave interrupt controllers with command decode and acknowledge.
// Assumes i_io strobes and i_inta are one-cycle pulses on i_core_clk; i_irq are pins.
`timescale 1ns/100ps
module pic_pair import pic_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire pic_io_t i_io,
   input wire logic i_inta,
   input wire logic [15:0] i_irq,
   output logic [7:0] o_rdata,
   output logic [7:0] o_vector,
   output logic o_int,
   output logic [1:0][7:0] o_init_word
);
   function automatic logic [7:0] pic_rot(input logic [7:0] v, input logic [2:0] sh);
      logic [15:0] w;
      w = {v, v} >> sh;
      return w[7:0];
   endfunction

   // Index 0 is the highest priority after rotation
   function automatic logic [3:0] pic_first(input logic [7:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [7:0] pic_bit(input logic [2:0] lvl);
      return 8'h01 << lvl;
   endfunction

   logic [15:0] irq_s1;
   logic [15:0] irq_s2;
   logic [15:0] irq_s3;
   logic [15:0] rise;
   pic_ctl_t ctl [2];
   pic_ctl_t next_ctl [2];
   logic [7:0] req [2];
   logic found [2];
   logic [2:0] lvl [2];
   logic [2:0] top_isr [2];
   logic poll_rd [2];
   logic ack [2];
   logic rd_hit [2];
   logic [7:0] rd_val [2];
   logic slave_chain;
   logic [7:0] next_rdata;
   logic [7:0] next_vector;

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         irq_s1 <= 16'h0000;
         irq_s2 <= 16'h0000;
         irq_s3 <= 16'h0000;
      end else begin
         irq_s1 <= i_irq;
         irq_s2 <= irq_s1;
         irq_s3 <= irq_s2;
      end
   end

   assign rise = irq_s2 & ~irq_s3;
   assign slave_chain = found[0] && (lvl[0] == PIC_CASC_LINE);
   assign ack[0] = (i_inta || poll_rd[0]) && found[0];
   assign ack[1] = ((i_inta && slave_chain) || poll_rd[1]) && found[1];

   for (genvar c = 0; c < 2; c++) begin : g_ctl
      localparam logic [7:0] BASE = (c == 0) ? PIC_MST_BASE : PIC_SLV_BASE;
      logic wr_base;
      logic wr_odd;
      logic rd_base;
      logic rd_odd;
      logic [2:0] sh;
      logic [7:0] cand;
      logic [3:0] fq;
      logic [3:0] fs;
      logic [7:0] d;

      assign d = i_io.data;
      assign wr_base = i_io.wr && (i_io.addr == BASE);
      assign wr_odd = i_io.wr && (i_io.addr == 8'(BASE + 8'h01));
      assign rd_base = i_io.rd && (i_io.addr == BASE);
      assign rd_odd = i_io.rd && (i_io.addr == 8'(BASE + 8'h01));
      assign poll_rd[c] = rd_base && ctl[c].poll;

      // Master line 2 follows the slave output as a level, not an edge
      if (c == 0) begin : g_mst
         assign req[c] = {ctl[c].request_register[7:3], found[1], ctl[c].request_register[1:0]};
      end else begin : g_slv
         assign req[c] = ctl[c].request_register;
      end

      // Masking master line 2 drops its cascade input, hiding every slave line
      assign sh = 3'(ctl[c].lowest + 3'h1);
      assign cand = ctl[c].special_mask_bit ? (req[c] & ~ctl[c].line_mask_register & ~ctl[c].in_service_register)
                               : (req[c] & ~ctl[c].line_mask_register);
      assign fq = pic_first(pic_rot(cand, sh));
      assign fs = pic_first(pic_rot(ctl[c].in_service_register, sh));
      assign found[c] = fq[3] && (ctl[c].special_mask_bit || !fs[3] || (fq[2:0] < fs[2:0]));
      assign lvl[c] = 3'(fq[2:0] + sh);
      assign top_isr[c] = 3'(fs[2:0] + sh);
      assign rd_hit[c] = rd_base || rd_odd;

      always_comb begin
         if (rd_odd) begin
            rd_val[c] = ctl[c].line_mask_register;
         end else if (ctl[c].poll) begin
            rd_val[c] = {found[c], 4'h0, lvl[c]};
         end else if (ctl[c].read_isr) begin
            rd_val[c] = ctl[c].in_service_register;
         end else begin
            rd_val[c] = req[c];
         end
      end

      always_comb begin
         next_ctl[c] = ctl[c];
         if (ack[c]) begin
            next_ctl[c].request_register = ctl[c].request_register & ~pic_bit(lvl[c]);
            if (!ctl[c].aeoi) begin
               next_ctl[c].in_service_register = ctl[c].in_service_register | pic_bit(lvl[c]);
            end else if (ctl[c].rot_aeoi) begin
               next_ctl[c].lowest = lvl[c];
            end
         end
         // A new edge in the acknowledge cycle survives the clear
         next_ctl[c].request_register = next_ctl[c].request_register | rise[c*8 +: 8];
         if (poll_rd[c]) begin
            next_ctl[c].poll = 1'b0;
         end
         if (wr_base && d[PIC_SEL_BIT]) begin
            // Upper bits and call-interval bit are kept but steer nothing
            next_ctl[c].init_word_one = d | PIC_LEVEL_TRIGGER_BIT_ONE;
            next_ctl[c].step = PIC_STEP_VEC;
            next_ctl[c].line_mask_register = PIC_IMR_RST;
            next_ctl[c].in_service_register = 8'h00;
            next_ctl[c].lowest = PIC_LOWEST_RST;
            next_ctl[c].special_mask_bit = 1'b0;
            next_ctl[c].poll = 1'b0;
            next_ctl[c].read_isr = 1'b0;
            next_ctl[c].rot_aeoi = 1'b0;
         end else if (wr_base && d[PIC_MISC_BIT]) begin
            if (d[PIC_SPECIAL_MASK_ENABLE_BIT]) begin
               next_ctl[c].special_mask_bit = d[PIC_SMM_BIT];
            end
            next_ctl[c].poll = d[PIC_POLL_BIT];
            if (d[PIC_RDEN_BIT]) begin
               next_ctl[c].read_isr = d[PIC_RDSEL_BIT];
            end
         end else if (wr_base) begin
            unique case (d[7:5])
               PIC_OP_ROT_CLR: begin
                  next_ctl[c].rot_aeoi = 1'b0;
               end
               PIC_OP_NS_EOI: begin
                  next_ctl[c].in_service_register = next_ctl[c].in_service_register & ~pic_bit(top_isr[c]);
               end
               PIC_OP_NOP: begin
               end
               PIC_OP_SP_EOI: begin
                  next_ctl[c].in_service_register = next_ctl[c].in_service_register & ~pic_bit(d[2:0]);
               end
               PIC_OP_ROT_SET: begin
                  next_ctl[c].rot_aeoi = 1'b1;
               end
               PIC_OP_ROT_NS: begin
                  next_ctl[c].in_service_register = next_ctl[c].in_service_register & ~pic_bit(top_isr[c]);
                  if (ctl[c].in_service_register != 8'h00) begin
                     next_ctl[c].lowest = top_isr[c];
                  end
               end
               PIC_OP_SET_PRI: begin
                  next_ctl[c].lowest = d[2:0];
               end
               PIC_OP_ROT_SP: begin
                  next_ctl[c].in_service_register = next_ctl[c].in_service_register & ~pic_bit(d[2:0]);
                  next_ctl[c].lowest = d[2:0];
               end
            endcase
         end else if (wr_odd) begin
            unique case (ctl[c].step)
               PIC_STEP_VEC: begin
                  next_ctl[c].vbase = d[7:3];
                  next_ctl[c].step = PIC_STEP_CAS;
               end
               PIC_STEP_CAS: begin
                  next_ctl[c].step = ctl[c].init_word_one[PIC_IC4_BIT] ? PIC_STEP_FOUR
                                                                      : PIC_STEP_OPER;
               end
               PIC_STEP_FOUR: begin
                  next_ctl[c].aeoi = d[PIC_AEOI_BIT];
                  next_ctl[c].step = PIC_STEP_OPER;
               end
               PIC_STEP_OPER: begin
                  next_ctl[c].line_mask_register = d;
               end
            endcase
         end
      end

      always_ff @(posedge i_core_clk or posedge i_rst) begin
         if (i_rst) begin
            ctl[c] <= PIC_CTL_RST;
         end else begin
            ctl[c] <= next_ctl[c];
         end
      end
   end

   always_comb begin
      next_rdata = o_rdata;
      if (rd_hit[0]) begin
         next_rdata = rd_val[0];
      end else if (rd_hit[1]) begin
         next_rdata = rd_val[1];
      end
      next_vector = o_vector;
      // No winner at acknowledge gives the spurious line 7 of the master
      if (i_inta) begin
         if (slave_chain && found[1]) begin
            next_vector = {ctl[1].vbase, lvl[1]};
         end else if (found[0]) begin
            next_vector = {ctl[0].vbase, lvl[0]};
         end else begin
            next_vector = {ctl[0].vbase, PIC_SPUR_LINE};
         end
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= 8'h00;
         o_vector <= 8'h00;
         o_int <= 1'b0;
         o_init_word <= {PIC_INIT_WORD_ONE_RST, PIC_INIT_WORD_ONE_RST};
      end else begin
         o_rdata <= next_rdata;
         o_vector <= next_vector;
         o_int <= found[0];
         o_init_word <= {next_ctl[1].init_word_one, next_ctl[0].init_word_one};
      end
   end
endmodule // pic_pair

/* tb/pic_pair_properties.sv */
// Port-level properties of pic_pair, bound to every instance of it.
// Assumes the host keeps the init order; the master's init step is tracked here.
`timescale 1ns/100ps
module pic_pair_properties import pic_pkg::*; (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire pic_io_t i_io,
   input wire logic i_inta,
   input wire logic [15:0] i_irq,
   input wire logic [7:0] o_rdata,
   input wire logic [7:0] o_vector,
   input wire logic o_int,
   input wire logic [1:0][7:0] o_init_word
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   logic [1:0] left, next_left;
   logic [7:0] mask, next_mask;
   logic poll, next_poll;
   wire logic wr1 = i_io.wr && i_io.addr == 8'h21;
   wire logic wr0 = i_io.wr && i_io.addr == PIC_MST_BASE;
   wire logic rd_any = i_io.rd && i_io.addr[6:1] == 6'h10;
   always_comb begin
      next_left = left;
      next_mask = mask;
      next_poll = poll;
      if (wr0 && i_io.data[4]) begin
         next_left = i_io.data[0] ? 2'd3 : 2'd2;
         next_mask = 8'h00;
         next_poll = 1'b0;
      end else if (wr0 && i_io.data[3]) begin
         next_poll = i_io.data[2];
      end else if (wr1 && left != 2'd0) begin
         next_left = left - 2'd1;
      end else if (wr1) begin
         next_mask = i_io.data;
      end else if (i_io.rd && i_io.addr == PIC_MST_BASE) begin
         next_poll = 1'b0;
      end
   end
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         left <= 2'd0;
         mask <= PIC_IMR_RST;
         poll <= 1'b0;
      end else begin
         left <= next_left;
         mask <= next_mask;
         poll <= next_poll;
      end
   end
   sequence s_mask_all;
      wr1 && left == 2'd0 && i_io.data == 8'hff;
   endsequence
   sequence s_no_unmask;
      !wr1;
   endsequence
   property p_store(logic sel, logic [7:0] word);
      sel && i_io.wr && i_io.data[4] |=> {word[7:4], word[1:0]} == $past({i_io.data[7:4],
         i_io.data[1:0]});
   endproperty
   chk_rdata_holds: assert property (!rd_any |=> $stable(o_rdata))
      else $error("read data moved without a read");
   chk_vector_holds: assert property (!i_inta |=> $stable(o_vector))
      else $error("vector moved without an acknowledge");
   chk_level_bit_one: assert property (o_init_word[0][3] && o_init_word[1][3])
      else $error("level trigger bit reads zero");
   chk_master_store: assert property (p_store(i_io.addr == 8'h20, o_init_word[0]))
      else $error("master first word not stored");
   chk_slave_store: assert property (p_store(i_io.addr == 8'ha0, o_init_word[1]))
      else $error("slave first word not stored");
   chk_init_kept: assert property (!(i_io.wr && i_io.data[4]) |=> $stable(o_init_word))
      else $error("first word changed without an init write");
   chk_mask_read: assert property (i_io.rd && i_io.addr == 8'h21 |=> o_rdata == $past(mask))
      else $error("mask readback wrong");
   chk_mask_quiet: assert property (s_mask_all ##1 s_no_unmask |=> !o_int)
      else $error("interrupt with every line masked");
   chk_poll_format: assert property (poll && i_io.rd && i_io.addr == 8'h20 |=> o_rdata[6:3] == 4'h0)
      else $error("poll byte malformed");
endmodule // pic_pair_properties
bind pic_pair pic_pair_properties chk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_io(i_io),
   .i_inta(i_inta), .i_irq(i_irq), .o_rdata(o_rdata), .o_vector(o_vector), .o_int(o_int),
   .o_init_word(o_init_word));

/* tb/pic_host_model.sv */
// Host CPU model: I/O writes and reads, acknowledge pulses, init sequences.
// Assumes pic_pair samples on the rising edge; this model drives on the falling one.
`timescale 1ns/100ps
module pic_host_model import pic_pkg::*; (
   input wire logic i_core_clk,
   input wire logic [7:0] i_rdata,
   input wire logic [7:0] i_vector,
   output pic_io_t o_io,
   output logic o_inta
);
   initial begin
      o_io = '0;
      o_inta = 1'b0;
   end
   // Released address and data lines show the inverse, never a stale copy; both strobes drop to zero
   task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_io = '{wr: w, rd: r, addr: a, data: d};
      @(negedge i_core_clk);
      o_io = '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b1, 1'b0, a, d);
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      cyc(1'b0, 1'b1, a, 8'h00);
      d = i_rdata;
   endtask
   task automatic ack(output logic [7:0] v);
      @(negedge i_core_clk);
      o_inta = 1'b1;
      @(negedge i_core_clk);
      o_inta = 1'b0;
      v = i_vector;
   endtask
   task automatic init(input logic [7:0] b, input logic [4:0] vb, input logic [7:0] cas);
      wr(b, 8'h11);
      wr(b + 8'h01, {vb, 3'b000});
      wr(b + 8'h01, cas);
      wr(b + 8'h01, 8'h01);
   endtask
   task automatic misc(input logic [7:0] b, input logic [2:0] low);
      wr(b, {5'b00001, low});
   endtask
   task automatic cmd(input logic [7:0] b, input logic [2:0] op, input logic [2:0] lvl);
      wr(b, {op, 2'b00, lvl});
   endtask
endmodule // pic_host_model

/* tb/pic_pair_tb.sv */
// Self-checking bench for pic_pair: init, masks, acknowledge, poll, priority.
// Assumes pic_host_model as the CPU and pic_pair_properties bound to the dut.
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin miscompares++; \
   $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module pic_pair_tb import pic_pkg::*; ;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   pic_io_t io;
   logic inta, o_int;
   logic [15:0] irq = 16'h0000;
   logic [7:0] rdata, vector, v;
   logic [1:0][7:0] init_word;
   int miscompares = 0;
   int tests_run = 0;
   int cycles = 0;
   always #10 i_core_clk = ~i_core_clk;
   pic_pair dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_io(io), .i_inta(inta),
      .i_irq(irq), .o_rdata(rdata), .o_vector(vector), .o_int(o_int), .o_init_word(init_word));
   pic_host_model host (.i_core_clk(i_core_clk), .i_rdata(rdata), .i_vector(vector),
      .o_io(io), .o_inta(inta));
   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge i_core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         complete_run();
      end
   end
   // Synchroniser plus edge detect needs a few cycles before the request shows
   task automatic settle();
      repeat (6) @(negedge i_core_clk);
   endtask
   initial begin
      repeat (6) @(negedge i_core_clk);
      i_rst = 1'b0;
      `CHK(init_word, {PIC_INIT_WORD_ONE_RST, PIC_INIT_WORD_ONE_RST})
      host.init(PIC_MST_BASE, 5'b00001, 8'h04);
      host.init(PIC_SLV_BASE, 5'b10000, 8'h02);
      `CHK(init_word[0], 8'h19)
      host.wr(8'h21, 8'hff);
      host.wr(8'h22, 8'h00);
      host.rd(8'h21, v);
      `CHK(v, 8'hff)
      irq[4] = 1'b1;
      settle();
      `CHK(o_int, 1'b0)
      host.wr(8'h21, 8'h04);
      settle();
      host.ack(v);
      `CHK(v, 8'h0c)
      irq[9] = 1'b1;
      host.cmd(8'h20, PIC_OP_NS_EOI, 3'h0);
      settle();
      `CHK(o_int, 1'b0)
      host.wr(8'h21, 8'h00);
      settle();
      host.ack(v);
      `CHK(v, 8'h81)
      host.cmd(8'ha0, PIC_OP_NS_EOI, 3'h0);
      host.cmd(8'h20, PIC_OP_NS_EOI, 3'h0);
      irq[3] = 1'b1;
      settle();
      host.rd(8'h20, v);
      `CHK(v, 8'h08)
      host.ack(v);
      host.misc(8'h20, 3'b011);
      host.misc(8'h20, 3'b001);
      host.rd(8'h20, v);
      `CHK(v, 8'h08)
      host.cmd(8'h20, PIC_OP_SP_EOI, 3'h3);
      host.rd(8'h20, v);
      `CHK(v, 8'h00)
      host.misc(8'h20, 3'b010);
      irq[5] = 1'b1;
      settle();
      host.misc(8'h20, 3'b100);
      host.rd(8'h20, v);
      `CHK(v, 8'h85)
      host.misc(8'h20, 3'b011);
      host.rd(8'h20, v);
      `CHK(v, 8'h20)
      host.cmd(8'h20, PIC_OP_NS_EOI, 3'h0);
      host.cmd(8'h20, PIC_OP_SET_PRI, 3'h3);
      irq[1] = 1'b1;
      irq[6] = 1'b1;
      settle();
      host.ack(v);
      `CHK(v, 8'h0e)
      host.cmd(8'h20, PIC_OP_NS_EOI, 3'h0);
      host.cmd(8'h20, PIC_OP_SET_PRI, 3'h7);
      irq[0] = 1'b1;
      settle();
      host.ack(v);
      irq[0] = 1'b0;
      host.cmd(8'h20, PIC_OP_ROT_NS, 3'h0);
      irq[0] = 1'b1;
      irq[7] = 1'b1;
      settle();
      host.ack(v);
      `CHK(v, 8'h09)
      host.cmd(8'h20, PIC_OP_ROT_SP, 3'h7);
      host.ack(v);
      `CHK(v, 8'h08)
      host.cmd(8'h20, PIC_OP_NOP, 3'h0);
      host.cmd(8'h20, PIC_OP_ROT_SET, 3'h0);
      host.cmd(8'h20, PIC_OP_ROT_CLR, 3'h0);
      host.rd(8'h20, v);
      `CHK(v, 8'h03)
      host.cmd(8'h20, PIC_OP_NS_EOI, 3'h0);
      irq[3] = 1'b0;
      host.wr(8'h21, 8'haa);
      host.wr(8'h20, 8'h11);
      host.rd(8'h21, v);
      `CHK(v, 8'h00)
      host.wr(8'h21, 8'h10);
      host.wr(8'h21, 8'h04);
      host.wr(8'h21, 8'h01);
      irq[3] = 1'b1;
      settle();
      host.ack(v);
      `CHK(v, 8'h13)
      complete_run();
   end
endmodule // pic_pair_tb
